// ### design/card_tape_reader_serial_tx.sv
// Top: APB registers, reader control sequence and serial line
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module card_tape_reader_serial_tx import reader_pkg::*; (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Operator buttons and sensing pins
  input wire buttons_s btn_pin,
  input wire sense_s sense_pin,
  input wire logic [7:0] perf_pin,
  // Feed and command from outside source
  input wire logic ext_feed_pin,
  input wire logic ext_stop_pin,
  input wire logic ext_eject_pin,
  // Outputs
  output logic line_q,
  output logic [7:0] par_code_q,
  output logic par_strobe_q,
  output logic eject_q,
  output logic advance_q
);
  logic [2:0] btn_s;
  logic [2:0] sense_s_w;
  logic [7:0] perf_s;
  logic [2:0] ext_s;
  logic [2:0] btn_d1_q;
  logic [CTRL_WIDTH-1:0] ctrl_q;
  logic [7:0] presel_q;
  logic [7:0] code_q;
  rd_state_e state_q;
  logic [31:0] ej_cnt_q;
  logic [7:0] ej_steps_q;
  logic end_seen_q;
  logic tx_go, tx_busy, tx_last;
  logic start_press, stop_press, eject_press;
  logic medium_in, medium_out, motor_run;
  logic start_req, stop_req, eject_req;
  logic code_hit, auto_eject, out_now;
  logic wr_en, rd_en, addr_ok;

  // ==========================================================
  // Pin synchronisers
  sync2 #(.W(3)) u_sync_btn (.pclk(pclk), .presetn(presetn), .async_in(btn_pin),
    .sync_out(btn_s));
  sync2 #(.W(3)) u_sync_sense (.pclk(pclk), .presetn(presetn), .async_in(sense_pin),
    .sync_out(sense_s_w));
  sync2 #(.W(8)) u_sync_perf (.pclk(pclk), .presetn(presetn), .async_in(perf_pin),
    .sync_out(perf_s));
  sync2 #(.W(3)) u_sync_ext (.pclk(pclk), .presetn(presetn),
    .async_in({ext_feed_pin, ext_stop_pin, ext_eject_pin}), .sync_out(ext_s));

  // ==========================================================
  // Press edges and sense levels
  assign start_press = btn_s[2] & ~btn_d1_q[2];
  assign stop_press = btn_s[1] & ~btn_d1_q[1];
  assign eject_press = btn_s[0] & ~btn_d1_q[0];
  assign medium_in = sense_s_w[2];
  assign medium_out = sense_s_w[1];
  assign motor_run = sense_s_w[0];

  // Feed source: the outside source replaces the button when selected
  assign start_req = ctrl_q[CTRL_FEED_EXT] ? ext_s[2] :
    (start_press | (ctrl_q[CTRL_FEED_AUTO] & medium_in));
  // In parallel mode the outside equipment commands stop and eject
  assign stop_req = stop_press | (ctrl_q[CTRL_PAR_EXT] & ext_s[1]);
  assign eject_req = eject_press | (ctrl_q[CTRL_PAR_EXT] & ext_s[0]);

  // Preselected code acts only when not handed to outside equipment
  assign code_hit = ctrl_q[CTRL_AUTO_CODE] && !ctrl_q[CTRL_PAR_EXT]
    && (code_q == presel_q);
  assign out_now = end_seen_q | medium_out;
  assign auto_eject = code_hit | (ctrl_q[CTRL_AUTO_END] & out_now);

  // Keep sending while reading and medium remains
  assign tx_go = (state_q == ST_READ) && !stop_req && !out_now && !code_hit
    && !(tx_busy && !tx_last);

  // ==========================================================
  // Serialiser
  frame_tx u_tx (.pclk(pclk), .presetn(presetn), .go(tx_go), .code(perf_s),
    .busy(tx_busy), .last_unit(tx_last), .line_q(line_q));

  // ==========================================================
  // Latch all eight positions together at each frame start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_q <= CODE_RST;
      par_code_q <= CODE_RST;
      par_strobe_q <= 1'b0;
      advance_q <= 1'b0;
      btn_d1_q <= '0;
    end else begin
      btn_d1_q <= btn_s;
      par_strobe_q <= tx_go;
      advance_q <= tx_last;
      if (tx_go) begin
        code_q <= perf_s;
        par_code_q <= perf_s;
      end
    end
  end

  // ==========================================================
  // Reader sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      end_seen_q <= 1'b0;
      eject_q <= 1'b0;
      ej_cnt_q <= '0;
      ej_steps_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          eject_q <= 1'b0;
          end_seen_q <= 1'b0;
          if (start_req && medium_in && motor_run && !tx_busy) begin
            state_q <= ST_READ;
          end
        end
        ST_READ: begin
          if (medium_out) begin
            end_seen_q <= 1'b1;
          end
          if (stop_req) begin
            state_q <= ST_STOP;
          end else if ((out_now || code_hit) && (!tx_busy || tx_last)) begin
            state_q <= auto_eject ? ST_EJECT : ST_IDLE;
            ej_cnt_q <= '0;
            ej_steps_q <= '0;
          end
        end
        ST_STOP: begin
          if (eject_req && !tx_busy) begin
            state_q <= ST_EJECT;
            ej_cnt_q <= '0;
            ej_steps_q <= '0;
          end else if (start_req && medium_in && motor_run && !tx_busy) begin
            state_q <= ST_READ;
          end
        end
        ST_EJECT: begin
          eject_q <= 1'b1;
          if (ej_cnt_q == 32'(EJECT_STEP_CYCLES - 1)) begin
            ej_cnt_q <= '0;
            ej_steps_q <= ej_steps_q + 8'd1;
            if (ej_steps_q == 8'(EJECT_STEPS - 1) || !medium_in) begin
              state_q <= ST_IDLE;
            end
          end else begin
            ej_cnt_q <= ej_cnt_q + 32'd1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // ==========================================================
  // APB slave, zero wait states
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  assign addr_ok = (paddr == CTRL_OFF) || (paddr == PRESEL_OFF)
    || (paddr == STATUS_OFF) || (paddr == CODE_OFF);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;

  // Writable configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      presel_q <= PRESEL_RST;
    end else if (wr_en && paddr == CTRL_OFF) begin
      ctrl_q <= pwdata[CTRL_WIDTH-1:0];
    end else if (wr_en && paddr == PRESEL_OFF) begin
      presel_q <= pwdata[7:0];
    end
  end

  // Read data registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en && !penable) begin
      case (paddr)
        CTRL_OFF: prdata <= {27'h000_0000, ctrl_q};
        PRESEL_OFF: prdata <= {24'h00_0000, presel_q};
        STATUS_OFF: prdata <= {24'h00_0000, state_q, tx_busy, medium_in, medium_out, motor_run};
        CODE_OFF: prdata <= {24'h00_0000, code_q};
        default: prdata <= '0;
      endcase
    end
  end
endmodule : card_tape_reader_serial_tx
`default_nettype wire

// ### design/reader_pkg.sv
// Package: constants, types and timing for the card and tape reader transmitter
package reader_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int BAUD = 110;
  localparam int UNIT_CYCLES = CLK_HZ / BAUD;
  localparam int UNITS_PER_FRAME = 11;
  localparam int CODE_BITS = 8;
  localparam int STOP_UNITS = 2;
  localparam int EJECT_RATIO = 16;
  localparam int EJECT_STEP_CYCLES = UNIT_CYCLES * UNITS_PER_FRAME / EJECT_RATIO;
  localparam int EJECT_STEPS = 80;

  // ==========================================================
  // Reset values
  localparam logic [7:0] PRESEL_RST = 8'h00;
  localparam logic [7:0] CODE_RST = 8'h00;

  // ==========================================================
  // Register map
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] PRESEL_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;
  localparam logic [11:0] CODE_OFF = 12'h00C;
  localparam int CTRL_AUTO_CODE = 0;
  localparam int CTRL_AUTO_END = 1;
  localparam int CTRL_PAR_EXT = 2;
  localparam int CTRL_FEED_EXT = 3;
  localparam int CTRL_FEED_AUTO = 4;
  localparam int CTRL_WIDTH = 5;

  // ==========================================================
  // Types
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_READ = 4'b0010,
    ST_STOP = 4'b0100,
    ST_EJECT = 4'b1000
  } rd_state_e;

  typedef struct packed {
    logic start;
    logic stop;
    logic eject;
  } buttons_s;

  typedef struct packed {
    logic medium_in;
    logic medium_out;
    logic motor_run;
  } sense_s;

  function automatic logic bit_at(input logic [31:0] w, input int idx);
    return w[idx];
  endfunction : bit_at

endpackage : reader_pkg

// ### design/sync2.sv
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;

  // ==========================================================
  // Only the second stage feeds logic
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : sync2
`default_nettype wire

// ### design/frame_tx.sv
// Start-stop serialiser: one start, eight code, two stop units
`timescale 1ns/100ps
`default_nettype none
module frame_tx import reader_pkg::*; (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Character in
  input wire logic go,
  input wire logic [7:0] code,
  // Status
  output logic busy,
  output logic last_unit,
  // Line: 1 = current flowing (marking)
  output logic line_q
);
  logic [31:0] tick_q;
  logic [3:0] unit_q;
  logic [10:0] shift_q;
  logic tick_end;

  assign tick_end = (tick_q == 32'(UNIT_CYCLES - 1));
  assign last_unit = busy && tick_end && (unit_q == 4'(UNITS_PER_FRAME - 1));

  // ==========================================================
  // Frame bits LSB first; line idles marking between frames
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      tick_q <= '0;
      unit_q <= '0;
      shift_q <= '1;
      line_q <= 1'b1;
    end else if (!busy) begin
      line_q <= 1'b1;
      if (go) begin
        busy <= 1'b1;
        tick_q <= '0;
        unit_q <= '0;
        shift_q <= {2'b11, code, 1'b0};
        line_q <= 1'b0;
      end
    end else if (tick_end) begin
      tick_q <= '0;
      if (unit_q == 4'(UNITS_PER_FRAME - 1)) begin
        busy <= go;
        unit_q <= '0;
        shift_q <= {2'b11, code, 1'b0};
        line_q <= go ? 1'b0 : 1'b1;
      end else begin
        unit_q <= unit_q + 4'd1;
        shift_q <= {1'b1, shift_q[10:1]};
        line_q <= shift_q[1];
      end
    end else begin
      tick_q <= tick_q + 32'd1;
    end
  end
endmodule : frame_tx
`default_nettype wire

// ### sim/reader_assertions.sv
// Checker: bus and line assertions on the reader top ports
`timescale 1ns/100ps
`default_nettype none
module reader_assertions import reader_pkg::*; (
  // Clock, reset and bus
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Line side
  input wire logic line_q,
  input wire logic par_strobe_q,
  input wire logic [7:0] par_code_q,
  input wire logic eject_q,
  input wire logic advance_q
);
  // ==========================================================
  // One domain, so clock and reset are given once
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  // Anything but the four word offsets is unmapped, misaligned offsets included
  wire unmap = (paddr != CTRL_OFF) && (paddr != PRESEL_OFF)
    && (paddr != STATUS_OFF) && (paddr != CODE_OFF);

  // ==========================================================
  // Bus answers
  a_ready_in_access: assert property (acc |-> pready) else $error("no ready");
  a_err_unmapped: assert property (acc && unmap |-> pslverr) else $error("no slverr");
  a_err_mapped: assert property (acc && !unmap |-> !pslverr) else $error("bad slverr");
  a_read_unmapped: assert property (acc && unmap && !pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  // ==========================================================
  // Line framing; a start unit is far longer than eight cycles
  a_start_spacing: assert property ($fell(line_q) |-> !line_q [*8]) else $error("start short");
  // Code bits may also fall, so the strobe is the antecedent, not the line
  a_latch_at_start: assert property (par_strobe_q |-> $fell(line_q))
    else $error("strobe without frame start");
  a_code_held: assert property (!par_strobe_q |-> $stable(par_code_q))
    else $error("latched code moved inside frame");
  a_strobe_pulse: assert property (par_strobe_q |=> !par_strobe_q) else $error("strobe long");
  a_advance_pulse: assert property (advance_q |=> !advance_q) else $error("advance long");
  a_eject_marking: assert property (eject_q |-> line_q) else $error("spacing in eject");
endmodule : reader_assertions

bind card_tape_reader_serial_tx reader_assertions chk_inst (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .pready, .pslverr, .line_q, .par_strobe_q, .par_code_q, .eject_q,
  .advance_q);
`default_nettype wire

// ### sim/station_model.sv
// Receiving station on the start-stop line
`timescale 1ns/100ps
`default_nettype none
module station_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Line: 1 = current
  input wire logic line_in,
  output logic got_start
);
  // A loop break is spacing, so it marks a start element
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_start <= 1'b0;
    end else if (!line_in) begin
      got_start <= 1'b1;
    end
  end
endmodule : station_model
`default_nettype wire

// ### sim/card_tape_reader_serial_tx_test.sv
// Testbench: registers, start gating, latching and line level
`timescale 1ns/100ps
`default_nettype none
module card_tape_reader_serial_tx_test import reader_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, line_q, got_start;
  logic par_strobe_q, eject_q, advance_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] perf_pin, par_code_q;
  logic err;
  logic ext_feed_pin, ext_stop_pin, ext_eject_pin;
  buttons_s btn_pin;
  sense_s sense_pin;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n;
  typedef struct packed {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] r; logic e;} row_s;
  row_s rows [10] = '{
    '{1'b0, CTRL_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, CTRL_OFF, 32'h0000_001F, 32'h0000_0000, 1'b0},
    '{1'b0, CTRL_OFF, 32'h0000_0000, 32'h0000_001F, 1'b0},
    '{1'b1, CTRL_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, PRESEL_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, PRESEL_OFF, 32'h0000_00A5, 32'h0000_0000, 1'b0},
    '{1'b0, PRESEL_OFF, 32'h0000_0000, 32'h0000_00A5, 1'b0},
    '{1'b0, CODE_OFF, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b1, 12'h010, 32'h0000_0005, 32'h0000_0000, 1'b1},
    '{1'b0, 12'h010, 32'h0000_0000, 32'h0000_0000, 1'b1}};

  // ==========================================================
  // Clock, design and far side
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  card_tape_reader_serial_tx card_tape_reader_serial_tx_inst (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .btn_pin, .sense_pin, .perf_pin,
    .ext_feed_pin, .ext_stop_pin, .ext_eject_pin, .line_q, .par_code_q,
    .par_strobe_q, .eject_q, .advance_q);
  station_model station_model_inst (.pclk, .presetn, .line_in(line_q), .got_start);

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Holds the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Held for several cycles to clear the pin synchroniser
  task automatic press(input buttons_s b);
    btn_pin <= b;
    repeat (5) @(posedge pclk);
    btn_pin <= 3'b000;
    @(posedge pclk);
  endtask : press

  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim

  // ==========================================================
  // Watchdog well beyond the planned run
  initial begin
    repeat (30000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} <= '0;
    btn_pin <= 3'b000;
    sense_pin <= 3'b001;
    perf_pin <= 8'h96;
    {ext_feed_pin, ext_stop_pin, ext_eject_pin} <= 3'b000;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      chk(32'(err), 32'(rows[i].e));
      if (!rows[i].wr) chk(rd, rows[i].r);
    end
    // Start with no medium must leave the line marking
    press(3'b100);
    repeat (30) @(posedge pclk);
    chk(32'(line_q), 32'h0000_0001);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0011);
    // Medium in: frame starts, character latched and held
    sense_pin.medium_in <= 1'b1;
    repeat (5) @(posedge pclk);
    press(3'b100);
    n = 0;
    while (line_q !== 1'b0 && n < 40) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(line_q), 32'h0000_0000);
    repeat (3) @(posedge pclk);
    chk(32'(par_code_q), 32'h0000_0096);
    perf_pin <= 8'h00;
    repeat (1000) @(posedge pclk);
    chk(32'(line_q), 32'h0000_0000);
    chk(32'(par_code_q), 32'h0000_0096);
    chk(32'(got_start), 32'h0000_0001);
    apb(1'b0, CODE_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0096);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_002D);
    // Eject and an outside stop are both refused while reading in normal mode
    press(3'b001);
    ext_stop_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    ext_stop_pin <= 1'b0;
    chk(32'(eject_q), 32'h0000_0000);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_002D);
    // Stop lets the running frame finish
    press(3'b010);
    repeat (20) @(posedge pclk);
    chk(32'(line_q), 32'h0000_0000);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_004D);
    // Eject pressed while the frame is in flight is refused, not held
    press(3'b001);
    repeat (5) @(posedge pclk);
    chk(32'(eject_q), 32'h0000_0000);
    // Reset mid-frame returns the line to marking
    presetn <= 1'b0;
    @(posedge pclk);
    #1;
    chk(32'(line_q), 32'h0000_0001);
    chk(32'(par_code_q), 32'h0000_0000);
    presetn <= 1'b1;
    repeat (5) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_0015);
    // Outside source feeds, then the outside equipment commands stop
    apb(1'b1, CTRL_OFF, 32'h0000_000C);
    ext_feed_pin <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'(line_q), 32'h0000_0000);
    ext_stop_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(rd, 32'h0000_004D);
    ext_eject_pin <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'(eject_q), 32'h0000_0000);
    {ext_feed_pin, ext_stop_pin, ext_eject_pin} <= 3'b000;
    @(posedge pclk);
    end_sim();
  end
endmodule : card_tape_reader_serial_tx_test
`default_nettype wire
